// ### src/fmd_core.sv
// Purpose : Register, RAM and I/O datapath of a 4-bit controller core
// Assumes : Instructions are issued by writes to the instruction register
// Notes   : Accumulator, carry, status, file bits, pointer and RAM keep
//           their contents across reset
//
// Summary of operation
// - ALU result goes to accumulator, overflow to carry for chaining.
// - Instructions set carry, clear carry, and copy carry into status.
// - Carry plus accumulator rotates one place left or right.
// - One-bit file select (0 or 4) picks RAM file, loaded from accumulator or operand.
// - A second file bit swaps with file select to stack it.
// - Four-bit digit pointer picks RAM digit and discrete latch.
// - Pointer steps itself while other data moves in same cycle.
// - Input channel instruction copies input pins into accumulator.
// - Two output channel registers load from accumulator or pattern.
// - Ten discrete latches; first four bidirectional, six output only.
// - Pointer-selected latch set or cleared; test copies pin to status.
// - Latch stays driven during input; read is the wired level.
// - Four bidirectional pins set or cleared by direct operand.
// - Core held in reset while reset high, runs once low.
// - Reset loads program counter with page 14, address 3F.
// - Reset clears latches, output channels and pending pattern, keeps datapath state and RAM.
// - Add uses M+A+C, subtract M-A-notC; both update carry.
// - Immediate store writes operand, steps pointer; status is nonzero.
// - RAM load copies digit to accumulator, optional file swap.
// - Store-and-step writes accumulator, steps pointer, optional swap.
// - Negate gives two's complement of accumulator modulo 16.
// - Status takes not-zero, carry or no-borrow per instruction.
// - Only seven carry instructions change carry flip-flop.
// - All instructions take one cycle; pattern takes two.
//
// The placing of the registers and the AXI4-Lite interface to the registers were decided locally.
`default_nettype none
module fmd_core
  import fmd_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        sys_rst,
  // AXI4-Lite write address and data
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Four-bit channels
  input  wire logic [3:0]  input_channel,
  output logic      [3:0]  output_channel_lo,
  output logic      [3:0]  output_channel_hi,
  // Discrete pins
  input  wire logic [3:0]  bidir_discrete_pins_in,
  output logic      [3:0]  bidir_discrete_pins_out,
  output logic      [3:0]  bidir_discrete_pins_oe,
  output logic      [5:0]  output_discrete_pins
);

  // ****************************************************************
  // State
  // ****************************************************************
  logic [3:0]  acc_q, acc_d, ptr_q, ptr_d;
  logic        carry_q, carry_d, status_q, status_d;
  logic        file_q, file_d, file_stack_bit_q, file_stack_bit_d;
  logic [3:0]  ram_q [0:31];
  logic [4:0]  ram_addr;
  logic        ram_we;
  logic [3:0]  ram_wd, ram_rd;
  logic [3:0]  ch_lo_q, ch_lo_d, ch_hi_q, ch_hi_d;
  logic [9:0]  dlat_q, dset, dclr;
  logic        pat_q;
  logic [7:0]  pat_val_q;
  logic [3:0]  pc_page_q;
  logic [5:0]  pc_addr_q;
  logic [3:0]  in_s1_q, in_s2_q, bd_s1_q, bd_s2_q;
  logic [9:0]  pin_lvl;
  logic        pin_sel;
  fmd_instr_t  ins;
  logic        exec;
  logic [3:0]  alu_a, alu_b, alu_s;
  logic        alu_ci, alu_sub, alu_co, nz;
  logic [4:0]  mreg_addr;

  // ****************************************************************
  // AXI4-Lite slave
  // ****************************************************************
  logic        aw_rdy_q, w_rdy_q, b_vld_q, ar_rdy_q, r_vld_q;
  logic [1:0]  b_resp_q, r_resp_q;
  logic [31:0] r_data_q;
  logic [3:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;
  logic        wr_go, wr_hit;

  // Both halves of a write held and no answer pending
  assign wr_go  = !aw_rdy_q && !w_rdy_q && !b_vld_q;
  assign wr_hit = (aw_addr_q == FMD_OFS_INSTR) && w_strb_q[0];
  assign exec   = wr_go && wr_hit && !pat_q;
  assign ins    = fmd_instr_t'(w_data_q);

  // Write address capture; address and data may come in either order
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_rdy_q  <= 1'b1;
      aw_addr_q <= 4'h0;
    end else if (s_axi_awvalid && aw_rdy_q) begin
      aw_rdy_q  <= 1'b0;
      aw_addr_q <= {s_axi_awaddr[3:2], 2'b00};
    end else if (b_vld_q && s_axi_bready) begin
      aw_rdy_q  <= 1'b1;
    end
  end

  // Write data capture
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      w_rdy_q  <= 1'b1;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (s_axi_wvalid && w_rdy_q) begin
      w_rdy_q  <= 1'b0;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end else if (b_vld_q && s_axi_bready) begin
      w_rdy_q  <= 1'b1;
    end
  end

  // Write response; only the instruction register accepts writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      b_vld_q  <= 1'b0;
      b_resp_q <= FMD_RESP_OK;
    end else if (wr_go) begin
      b_vld_q  <= 1'b1;
      b_resp_q <= exec ? FMD_RESP_OK : FMD_RESP_ERR;
    end else if (b_vld_q && s_axi_bready) begin
      b_vld_q  <= 1'b0;
    end
  end

  // Read channel; data answer one cycle after the address is taken
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ar_rdy_q <= 1'b1;
      r_vld_q  <= 1'b0;
      r_resp_q <= FMD_RESP_OK;
      r_data_q <= 32'h0000_0000;
    end else if (s_axi_arvalid && ar_rdy_q) begin
      ar_rdy_q <= 1'b0;
      r_vld_q  <= 1'b1;
      r_resp_q <= FMD_RESP_OK;
      if (s_axi_araddr[3:2] == FMD_OFS_CORE[3:2]) begin
        r_data_q <= {19'h0, pat_q, ptr_q, file_stack_bit_q, file_q,
                     status_q, carry_q, acc_q};
      end else if (s_axi_araddr[3:2] == FMD_OFS_IO[3:2]) begin
        r_data_q <= {6'h00, bd_s2_q, in_s2_q, dlat_q, ch_hi_q, ch_lo_q};
      end else if (s_axi_araddr[3:2] == FMD_OFS_PC[3:2]) begin
        r_data_q <= {22'h0, pc_page_q, pc_addr_q};
      end else begin
        r_data_q <= 32'h0000_0000;
        r_resp_q <= FMD_RESP_ERR;
      end
    end else if (r_vld_q && s_axi_rready) begin
      r_vld_q  <= 1'b0;
      ar_rdy_q <= 1'b1;
    end
  end

  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready  = w_rdy_q;
  assign s_axi_bvalid  = b_vld_q;
  assign s_axi_bresp   = b_resp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid  = r_vld_q;
  assign s_axi_rresp   = r_resp_q;
  assign s_axi_rdata   = r_data_q;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Pins are asynchronous to the core clock; two stages before use
  always_ff @(posedge clk) begin
    in_s1_q <= input_channel;
    in_s2_q <= in_s1_q;
    bd_s1_q <= bidir_discrete_pins_in;
    bd_s2_q <= bd_s1_q;
  end

  // Output-only pins read back their own latch
  assign pin_lvl = {dlat_q[9:4], bd_s2_q};
  assign pin_sel = (ptr_q < 4'hA) ? pin_lvl[ptr_q] : 1'b0;

  // ****************************************************************
  // RAM and ALU
  // ****************************************************************
  assign ram_addr  = {file_q, ptr_q};
  assign ram_rd    = ram_q[ram_addr];
  assign mreg_addr = (ins.imm == 4'h0) ? 5'h00 : {1'b1, ins.imm};

  fmd_alu u_alu (
    .opa  (alu_a),
    .opb  (alu_b),
    .cin  (alu_ci),
    .sub  (alu_sub),
    .sum  (alu_s),
    .cout (alu_co)
  );
  assign nz = |alu_s;

  // Operand steering; pointer ops use the ALU while the bus moves data
  always_comb begin
    alu_a   = acc_q;
    alu_b   = ram_rd;
    alu_ci  = 1'b0;
    alu_sub = 1'b0;
    case (ins.op)
      OP_PTR_INC, OP_ST_ACC_UP, OP_ST_IMM_UP: begin
        alu_a = ptr_q;
        alu_b = 4'h1;
      end
      OP_PTR_DEC, OP_ST_ACC_DN: begin
        alu_a = ptr_q; alu_b = 4'h1; alu_sub = 1'b1; alu_ci = 1'b1;
      end
      OP_PTR_ADD: begin alu_a = ptr_q; alu_b = acc_q; end
      OP_PTR_SUB: begin
        alu_a = ptr_q; alu_b = acc_q; alu_sub = 1'b1; alu_ci = 1'b1;
      end
      OP_ADD_IMM:   alu_b = ins.imm;
      OP_ADD_CARRY: begin alu_a = ram_rd; alu_b = acc_q;
                          alu_ci = carry_q; end
      OP_SUB_CARRY: begin alu_a = ram_rd; alu_b = acc_q;
                          alu_sub = 1'b1; alu_ci = carry_q; end
      OP_DEC_ADD:   alu_b = FMD_DAA_ADJ;
      OP_DEC_SUB:   alu_b = FMD_DAS_ADJ;
      OP_NEG_ACC: begin
        alu_a = 4'h0; alu_b = acc_q; alu_sub = 1'b1; alu_ci = 1'b1;
      end
      OP_M_NE_I: begin alu_a = ram_rd; alu_b = ins.imm;
                       alu_sub = 1'b1; alu_ci = 1'b1; end
      OP_PTR_NE_I: begin alu_a = ptr_q; alu_b = ins.imm;
                         alu_sub = 1'b1; alu_ci = 1'b1; end
      OP_A_NE_M, OP_A_LE_M: begin alu_a = ram_rd; alu_b = acc_q;
                                  alu_sub = 1'b1; alu_ci = 1'b1; end
      OP_A_LE_I: begin alu_a = ins.imm; alu_b = acc_q;
                       alu_sub = 1'b1; alu_ci = 1'b1; end
      default: ;
    endcase
  end

  // ****************************************************************
  // Instruction execution
  // ****************************************************************
  // Next state of every datapath register for the issued instruction
  always_comb begin
    acc_d = acc_q; carry_d = carry_q; status_d = status_q;
    file_d = file_q; file_stack_bit_d = file_stack_bit_q; ptr_d = ptr_q;
    ram_we = 1'b0; ram_wd = acc_q;
    ch_lo_d = ch_lo_q; ch_hi_d = ch_hi_q;
    dset = 10'h000; dclr = 10'h000;
    case (ins.op)
      OP_PTR_TO_A:  acc_d = ptr_q;
      OP_STK_TO_A:  acc_d = {1'b0, file_stack_bit_q, 2'b00};
      OP_XCH_MREG:  acc_d = ram_q[mreg_addr];
      OP_A_TO_FILE: file_d = acc_q[2];
      OP_A_TO_PTR:  ptr_d = acc_q;
      OP_I_TO_FILE: file_d = ins.imm[2];
      OP_I_TO_PTR:  ptr_d = ins.imm;
      OP_PTR_INC:   begin ptr_d = alu_s; status_d = nz; end
      OP_PTR_DEC, OP_PTR_SUB: begin ptr_d = alu_s; status_d = alu_co; end
      OP_PTR_ADD:   begin ptr_d = alu_s; status_d = alu_co; end
      OP_LD_ACC_M:  acc_d = ram_rd;
      OP_XCH_ACC_M: begin acc_d = ram_rd; ram_we = 1'b1; end
      OP_ST_ACC_UP: begin ram_we = 1'b1; ptr_d = alu_s;
                          status_d = nz; end
      OP_ST_ACC_DN: begin ram_we = 1'b1; ptr_d = alu_s;
                          status_d = alu_co; end
      OP_ST_IMM_UP: begin ram_we = 1'b1; ram_wd = ins.imm;
                          ptr_d = alu_s; status_d = nz; end
      OP_I_TO_A:    acc_d = ins.imm;
      OP_ADD_IMM, OP_ADD_M: begin acc_d = alu_s; status_d = alu_co; end
      OP_ADD_CARRY, OP_SUB_CARRY: begin
        acc_d = alu_s; carry_d = alu_co; status_d = alu_co;
      end
      OP_DEC_ADD: if (carry_q || acc_q > FMD_BCD_MAX) begin
        acc_d = alu_s; carry_d = 1'b1;
      end
      OP_DEC_SUB: if (!carry_q) acc_d = alu_s;
      OP_NEG_ACC:   acc_d = alu_s;
      OP_CARRY_SET: carry_d = 1'b1;
      OP_CARRY_CLR: carry_d = 1'b0;
      OP_CARRY_TST: status_d = carry_q;
      OP_ROT_LEFT:  {carry_d, acc_d} = {acc_q, carry_q};
      OP_ROT_RIGHT: {acc_d, carry_d} = {carry_q, acc_q};
      OP_M_NE_I, OP_PTR_NE_I, OP_A_NE_M: status_d = nz;
      OP_A_LE_I, OP_A_LE_M: status_d = alu_co;
      OP_MBIT_SET: begin ram_we = 1'b1;
        ram_wd = ram_rd | (4'h1 << ins.imm[1:0]); end
      OP_MBIT_CLR: begin ram_we = 1'b1;
        ram_wd = ram_rd & ~(4'h1 << ins.imm[1:0]); end
      OP_MBIT_TST: status_d = ram_rd[ins.imm[1:0]];
      OP_PIN_SET: if (ptr_q < 4'hA) dset[ptr_q] = 1'b1;
      OP_PIN_CLR: if (ptr_q < 4'hA) dclr[ptr_q] = 1'b1;
      OP_PIN_TST: status_d = pin_sel;
      OP_DPIN_SET: dset[ins.imm[1:0]] = 1'b1;
      OP_DPIN_CLR: dclr[ins.imm[1:0]] = 1'b1;
      OP_CH_TO_A:  acc_d = in_s2_q;
      OP_A_TO_CH: if (ins.imm[0]) ch_hi_d = acc_q;
                  else ch_lo_d = acc_q;
      default: ;
    endcase
    // Memory-register exchange writes the accumulator to its own digit
    if (ins.op == OP_XCH_MREG) ram_we = 1'b0;
    // Optional file swap works on the old file bits; a file load with swap sets both bits to the old stack bit
    if (ins.swap || ins.op == OP_FILE_SWP) begin
      file_d           = file_stack_bit_d;
      file_stack_bit_d = file_q;
      if (ins.op == OP_A_TO_FILE || ins.op == OP_I_TO_FILE) begin
        file_stack_bit_d = file_d == file_q ? file_q : file_d;
      end
    end
  end

  // Datapath registers; deliberately not reset
  always_ff @(posedge clk) begin
    if (exec) begin
      acc_q            <= acc_d;
      carry_q          <= carry_d;
      status_q         <= status_d;
      file_q           <= file_d;
      file_stack_bit_q <= file_stack_bit_d;
      ptr_q            <= ptr_d;
    end
  end

  // RAM write; the read above sees the old digit this cycle
  always_ff @(posedge clk) begin
    if (exec && ram_we) ram_q[ram_addr] <= ram_wd;
    if (exec && ins.op == OP_XCH_MREG) ram_q[mreg_addr] <= acc_q;
  end

  // Pattern takes a second cycle to land in the output channels
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pat_q     <= 1'b0;
      pat_val_q <= 8'h00;
    end else begin
      pat_q     <= exec && ins.op == OP_PATTERN;
      if (exec) pat_val_q <= ins.pattern;
    end
  end

  // Output channel holding registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ch_lo_q <= 4'h0;
      ch_hi_q <= 4'h0;
    end else if (pat_q) begin
      ch_lo_q <= pat_val_q[3:0];
      ch_hi_q <= pat_val_q[7:4];
    end else if (exec) begin
      ch_lo_q <= ch_lo_d;
      ch_hi_q <= ch_hi_d;
    end
  end

  // Discrete latches, one flop per pin
  genvar gi;
  generate
    for (gi = 0; gi < FMD_NUM_DPIN; gi++) begin : g_dlat
      always_ff @(posedge clk) begin
        if (sys_rst) dlat_q[gi] <= 1'b0;
        else if (exec && dset[gi]) dlat_q[gi] <= 1'b1;
        else if (exec && dclr[gi]) dlat_q[gi] <= 1'b0;
      end
    end
  endgenerate

  // Program counter; steps within its page for each instruction
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pc_page_q <= FMD_RST_PAGE;
      pc_addr_q <= FMD_RST_ADDR;
    end else if (exec) begin
      pc_addr_q <= pc_addr_q + 6'h01;
    end
  end

  // ****************************************************************
  // Pin drive
  // ****************************************************************
  // Open drain: the latch drives while set, even while being read
  assign output_channel_lo       = ch_lo_q;
  assign output_channel_hi       = ch_hi_q;
  assign bidir_discrete_pins_out = dlat_q[3:0];
  assign bidir_discrete_pins_oe  = dlat_q[3:0];
  assign output_discrete_pins    = dlat_q[9:4];

endmodule // fmd_core
`default_nettype wire

// ### src/fmd_pkg.sv
// Purpose : Shared constants and types for the 4-bit datapath core
// Assumes : 10 MHz clock, AXI4-Lite register access, 32-bit data
// Notes   : Opcode values are the encoding of the instruction register
`default_nettype none
package fmd_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [3:0] FMD_OFS_INSTR = 4'h0; // Instruction issue, write
  localparam logic [3:0] FMD_OFS_CORE  = 4'h4; // Core state, read
  localparam logic [3:0] FMD_OFS_IO    = 4'h8; // Channel and pin state, read
  localparam logic [3:0] FMD_OFS_PC    = 4'hC; // Program counter, read

  // ****************************************************************
  // Reset values and bus answers
  // ****************************************************************
  localparam logic [3:0] FMD_RST_PAGE = 4'hE;  // Page 14
  localparam logic [5:0] FMD_RST_ADDR = 6'h3F;
  localparam logic [1:0] FMD_RESP_OK  = 2'h0;
  localparam logic [1:0] FMD_RESP_ERR = 2'h2;
  localparam int         FMD_NUM_DPIN = 10;
  localparam int         FMD_NUM_BIDI = 4;
  localparam logic [3:0] FMD_DAA_ADJ  = 4'h6;  // Decimal add correction
  localparam logic [3:0] FMD_DAS_ADJ  = 4'hA;  // Decimal sub correction
  localparam logic [3:0] FMD_BCD_MAX  = 4'h9;

  // ****************************************************************
  // Instruction opcodes
  // ****************************************************************
  typedef enum logic [5:0] {
    OP_NOP      = 6'h00, OP_PTR_TO_A  = 6'h01, OP_STK_TO_A  = 6'h02,
    OP_XCH_MREG = 6'h03, OP_A_TO_FILE = 6'h04, OP_A_TO_PTR  = 6'h05,
    OP_I_TO_FILE= 6'h06, OP_I_TO_PTR  = 6'h07, OP_PTR_INC   = 6'h08,
    OP_PTR_DEC  = 6'h09, OP_PTR_ADD   = 6'h0A, OP_PTR_SUB   = 6'h0B,
    OP_FILE_SWP = 6'h0C, OP_LD_ACC_M  = 6'h0D, OP_XCH_ACC_M = 6'h0E,
    OP_ST_ACC_UP= 6'h0F, OP_ST_ACC_DN = 6'h10, OP_ST_IMM_UP = 6'h11,
    OP_I_TO_A   = 6'h12, OP_ADD_IMM   = 6'h13, OP_ADD_CARRY = 6'h14,
    OP_SUB_CARRY= 6'h15, OP_ADD_M     = 6'h16, OP_DEC_ADD   = 6'h17,
    OP_DEC_SUB  = 6'h18, OP_NEG_ACC   = 6'h19, OP_CARRY_SET = 6'h1A,
    OP_CARRY_CLR= 6'h1B, OP_CARRY_TST = 6'h1C, OP_ROT_LEFT  = 6'h1D,
    OP_ROT_RIGHT= 6'h1E, OP_M_NE_I    = 6'h1F, OP_PTR_NE_I  = 6'h20,
    OP_A_NE_M   = 6'h21, OP_A_LE_I    = 6'h22, OP_A_LE_M    = 6'h23,
    OP_MBIT_SET = 6'h24, OP_MBIT_CLR  = 6'h25, OP_MBIT_TST  = 6'h26,
    OP_PIN_SET  = 6'h27, OP_PIN_CLR   = 6'h28, OP_PIN_TST   = 6'h29,
    OP_DPIN_SET = 6'h2A, OP_DPIN_CLR  = 6'h2B, OP_CH_TO_A   = 6'h2C,
    OP_A_TO_CH  = 6'h2D, OP_PATTERN   = 6'h2E
  } fmd_op_t;

  // Instruction register word, high bits first
  typedef struct packed {
    logic [12:0] unused;
    logic [7:0]  pattern; // [18:11] hi channel nibble above lo nibble
    logic        swap;    // [10] exchange file bits after execution
    logic [3:0]  imm;     // [9:6] operand
    fmd_op_t     op;      // [5:0]
  } fmd_instr_t;

endpackage : fmd_pkg
`default_nettype wire

// ### src/fmd_alu.sv
// Purpose : 4-bit adder/subtractor with carry in and carry out
// Assumes : Subtract computes a + ~b + cin, so cout means no borrow
// Notes   : Purely combinational
`default_nettype none
module fmd_alu
  import fmd_pkg::*;
(
  // Operands
  input  wire logic [3:0] opa,
  input  wire logic [3:0] opb,
  input  wire logic       cin,
  input  wire logic       sub,
  // Result
  output logic      [3:0] sum,
  output logic            cout
);

  logic [4:0] total;

  // One adder serves both directions; inverting b saves a second one
  always_comb begin
    total = {1'b0, opa} + {1'b0, (sub ? ~opb : opb)} + {4'h0, cin};
    sum   = total[3:0];
    cout  = total[4];
  end

endmodule // fmd_alu
`default_nettype wire

// ### bench/fmd_pins.sv
// Purpose: Switches wired onto the core's input and discrete pins
// Assumes: Latch and switch combine as a wired OR
// Notes  : Pure wiring, no delay
`default_nettype none
module fmd_pins (
  // Switch settings
  input  wire logic [3:0] sw_ch,
  input  wire logic [3:0] sw_pin,
  // Core side
  input  wire logic [3:0] drv,
  input  wire logic [3:0] oe,
  output logic      [3:0] ch,
  output logic      [3:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  // Latch stays on the wire, so a read sees both drivers
  assign pin = (drv & oe) | sw_pin;
  assign ch  = sw_ch;
endmodule // fmd_pins
`default_nettype wire

// ### bench/fmd_core_chk.sv
// Purpose: Port-level checks of the datapath core
// Assumes: Sees only the core's ports
// Notes  : Bound to every core instance
`default_nettype none
module fmd_core_chk
  import fmd_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        s_axi_awready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Pins
  input wire logic [3:0]  output_channel_lo,
  input wire logic [3:0]  output_channel_hi,
  input wire logic [3:0]  bidir_discrete_pins_out,
  input wire logic [3:0]  bidir_discrete_pins_oe,
  input wire logic [5:0]  output_discrete_pins
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************
  // Bus and pin relations
  // ****************
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid)
    else $error("read not answered");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  wr_hold_a: assert property (wr_wait |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
  wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during answer");
  pin_drive_a: assert property (
    bidir_discrete_pins_oe == bidir_discrete_pins_out)
    else $error("latch not on pin");
  chan_cause_a: assert property ($changed({output_channel_hi,
    output_channel_lo}) |-> s_axi_bvalid || $past(s_axi_bvalid) ||
    $past(sys_rst)) else $error("channel moved without instruction");
  latch_cause_a: assert property ($changed({output_discrete_pins,
    bidir_discrete_pins_out}) |-> s_axi_bvalid || $past(sys_rst))
    else $error("latch moved without instruction");
  reset_clear_a: assert property (disable iff (1'b0) sys_rst |=>
    {output_channel_hi, output_channel_lo, output_discrete_pins,
     bidir_discrete_pins_out} == 18'h00000) else $error("reset left pins set");
endmodule // fmd_core_chk
bind fmd_core fmd_core_chk u_chk (.*);
`default_nettype wire

// ### bench/four_bit_mcu_datapath_io_tb_top.sv
// Purpose: Self-checking bench for the datapath core
// Assumes: Instructions are issued over the register bus
// Notes  : Acc, carry and pointer are set by instructions before use
`default_nettype none
module four_bit_mcu_datapath_io_tb_top
  import fmd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic        s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb, input_channel;
  logic [3:0]  output_channel_lo, output_channel_hi, sw_ch, sw_pin;
  logic [3:0]  bidir_discrete_pins_in, bidir_discrete_pins_out;
  logic [3:0]  bidir_discrete_pins_oe;
  logic [5:0]  output_discrete_pins;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, s_axi_rdata, q;
  int          err_total, n_tests;
  localparam fmd_op_t OPS [7] = '{OP_ADD_CARRY, OP_SUB_CARRY, OP_NEG_ACC,
    OP_ROT_LEFT, OP_ROT_RIGHT, OP_CARRY_CLR, OP_CARRY_TST};
  localparam logic [7:0] EXP [7] = '{8'h31, 8'h36, 8'h3A, 8'h35, 8'h3A,
    8'h2A, 8'h0A};
  fmd_core dut (.*);
  fmd_pins u_pins (.sw_ch(sw_ch), .sw_pin(sw_pin),
    .drv(bidir_discrete_pins_out), .oe(bidir_discrete_pins_oe),
    .ch(input_channel), .pin(bidir_discrete_pins_in));
  // ****************
  // Bus tasks
  // ****************
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Hold each channel until its own handshake edge
  task automatic wr(input fmd_op_t op, input logic [3:0] i,
                    input logic [7:0] p = 8'h00, input logic s = 1'b0);
    @(posedge clk);
    s_axi_wdata   <= {13'h0000, p, s, i, op};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk("bresp", {30'h0, FMD_RESP_OK}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [3:0] a, input logic [1:0] r = FMD_RESP_OK);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    q = s_axi_rdata;
    chk("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Clock and watchdog; the tests need well under 3000 cycles
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial begin
    repeat (8000) @(posedge clk);
    err_total++;
    results();
  end
  // ****************
  // Tests
  // ****************
  initial begin
    {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h8;
    {s_axi_arvalid, s_axi_rready, s_axi_wdata} = 34'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb} = {FMD_OFS_INSTR, 8'h0F};
    {sw_ch, sw_pin, err_total, n_tests} = {8'h50, 64'h0};
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    rd(FMD_OFS_PC);
    chk("pc", {22'h0, FMD_RST_PAGE, FMD_RST_ADDR}, q);
    rd(FMD_OFS_IO);
    chk("io", 32'h0, q & 32'h0003FFFF);
    wr(OP_CH_TO_A, 4'h0);
    rd(FMD_OFS_CORE);
    chk("in", 32'h5, q & 32'hF);
    wr(OP_PATTERN, 4'h0, 8'hA5);
    repeat (2) @(posedge clk);
    chk("chan", 32'hA5,
        {24'h0, output_channel_hi, output_channel_lo});
    wr(OP_I_TO_FILE, 4'h0);
    wr(OP_I_TO_PTR, 4'h0);
    wr(OP_ST_IMM_UP, 4'h7);
    rd(FMD_OFS_CORE);
    chk("step", 32'h120, q & 32'hF20);
    wr(OP_PTR_DEC, 4'h0);
    wr(OP_I_TO_A, 4'h9);
    wr(OP_CARRY_SET, 4'h0);
    foreach (OPS[k]) begin
      wr(OPS[k], 4'h0);
      rd(FMD_OFS_CORE);
      chk("core", {24'h0, EXP[k]}, q & 32'h3F);
    end
    wr(OP_PTR_DEC, 4'h0);
    rd(FMD_OFS_CORE);
    chk("wrap", 32'hF00, q & 32'hF20);
    wr(OP_I_TO_PTR, 4'h9);
    wr(OP_PIN_SET, 4'h0);
    chk("dout", 32'h20, {26'h0, output_discrete_pins});
    wr(OP_DPIN_SET, 4'h2);
    chk("bidir", 32'h4, {28'h0, bidir_discrete_pins_out});
    wr(OP_I_TO_PTR, 4'h2);
    wr(OP_PIN_TST, 4'h0);
    rd(FMD_OFS_CORE);
    chk("wired", 32'h20, q & 32'h20);
    wr(OP_DPIN_CLR, 4'h2);
    wr(OP_PIN_TST, 4'h0);
    rd(FMD_OFS_CORE);
    chk("test", 32'h0, q & 32'h20);
    wr(OP_I_TO_FILE, 4'h4);
    wr(OP_FILE_SWP, 4'h0);
    wr(OP_I_TO_FILE, 4'h0);
    wr(OP_LD_ACC_M, 4'h0, 8'h00, 1'b1);
    rd(FMD_OFS_CORE);
    chk("file", 32'h40, q & 32'hC0);
    rd(4'h2, FMD_RESP_ERR);
    chk("unmapped", 32'h0, q);
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(FMD_OFS_IO);
    chk("io", 32'h0, q & 32'h0003FFFF);
    rd(FMD_OFS_CORE);
    chk("kept", 32'h40, q & 32'hC0);
    results();
  end
endmodule // four_bit_mcu_datapath_io_tb_top
`default_nettype wire
